// *** hw/oag_consts.vh ***
// Constants for the operand address generator
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
// Addressing modes
`define OAG_MODE_INH  3'h0
`define OAG_MODE_IMM  3'h1
`define OAG_MODE_DIR  3'h2
`define OAG_MODE_EXT  3'h3
`define OAG_MODE_IX   3'h4
`define OAG_MODE_IX1  3'h5
`define OAG_MODE_IX2  3'h6
`define OAG_MODE_REL  3'h7
// Instruction groups
`define OAG_GRP_REGMEM 3'h0
`define OAG_GRP_RMW    3'h1
`define OAG_GRP_JMPBR  3'h2
`define OAG_GRP_BIT    3'h3
`define OAG_GRP_CTRL   3'h4
// Decoder states
`define OAG_ST_OPC  2'h0
`define OAG_ST_B1   2'h1
`define OAG_ST_B2   2'h2
`define OAG_ST_DONE 2'h3
`define OAG_ZERO8   8'h00
`endif

// *** hw/oag_operand_address_generator.v ***
// Operand fetch and effective address generation for the CPU core
`timescale 1ns/10ps
`default_nettype none
`include "oag_consts.vh"
module oag_operand_address_generator (
	// Clock and reset
	input  wire        clk,
	input  wire        srst,
	input  wire        clkEn,
	// Instruction byte stream
	input  wire        byteValid,
	input  wire [7:0]  byteData,
	input  wire [15:0] byteAddr,
	// CPU state
	input  wire [7:0]  indexReg,
	input  wire        branchCond,
	// Decode results
	output reg         decDone,
	output reg  [2:0]  decMode,
	output reg  [2:0]  decGroup,
	output reg  [1:0]  decLength,
	output reg         decBitBranch,
	output reg         decHasAddr,
	output reg  [15:0] operandAddr,
	output reg  [7:0]  immData,
	output reg  [15:0] nextPc,
	output reg         branchTaken,
	output reg  [15:0] branchTarget
);
	reg [1:0]  stateReg;
	reg [7:0]  opcReg;
	reg [7:0]  b1Reg;
	reg [15:0] opcAddrReg;
	reg [2:0]  mode;
	reg [2:0]  group;
	reg [1:0]  len;
	reg        bitBr;
	reg        relOnly;
	wire [3:0] hi = opcReg[7:4];
	wire [3:0] lo = opcReg[3:0];
	reg [1:0]  need;

	////////////////////////////////////////////////////////////////////
	// Opcode map decode, from the latched opcode
	always @* begin
		mode    = `OAG_MODE_INH;
		group   = `OAG_GRP_CTRL;
		bitBr   = 1'b0;
		relOnly = 1'b0;
		case (hi)
			4'h0: begin
				mode  = `OAG_MODE_DIR;
				group = `OAG_GRP_BIT;
				bitBr = 1'b1;
			end
			4'h1: begin
				mode  = `OAG_MODE_DIR;
				group = `OAG_GRP_BIT;
			end
			4'h2: begin
				mode    = `OAG_MODE_REL;
				group   = `OAG_GRP_JMPBR;
				relOnly = 1'b1;
			end
			4'h3: begin
				mode  = `OAG_MODE_DIR;
				group = `OAG_GRP_RMW;
			end
			4'h4, 4'h5: begin
				mode  = `OAG_MODE_INH;
				group = (lo == 4'h2) ? `OAG_GRP_REGMEM : `OAG_GRP_RMW;
			end
			4'h6: begin
				mode  = `OAG_MODE_IX1;
				group = `OAG_GRP_RMW;
			end
			4'h7: begin
				mode  = `OAG_MODE_IX;
				group = `OAG_GRP_RMW;
			end
			4'h8, 4'h9: begin
				mode  = `OAG_MODE_INH;
				group = `OAG_GRP_CTRL;
			end
			default: begin
				// A..F: register/memory column; low nibble C,D = jump in every row, AD = relative
				case (hi)
					4'hA: mode = `OAG_MODE_IMM;
					4'hB: mode = `OAG_MODE_DIR;
					4'hC: mode = `OAG_MODE_EXT;
					4'hD: mode = `OAG_MODE_IX2;
					4'hE: mode = `OAG_MODE_IX1;
					default: mode = `OAG_MODE_IX;
				endcase
				if (lo == 4'hC || lo == 4'hD) begin
					group = `OAG_GRP_JMPBR;
					if (hi == 4'hA && lo == 4'hD) begin
						mode    = `OAG_MODE_REL;
						relOnly = 1'b1;
					end
				end else begin
					group = `OAG_GRP_REGMEM;
				end
			end
		endcase
	end

	// Operand byte count per mode
	always @* begin
		case (mode)
			`OAG_MODE_IMM, `OAG_MODE_DIR, `OAG_MODE_IX1, `OAG_MODE_REL: need = 2'd1;
			`OAG_MODE_EXT, `OAG_MODE_IX2: need = 2'd2;
			default: need = 2'd0;
		endcase
		if (bitBr)
			need = 2'd2;
		len = need + 2'd1;
	end

	////////////////////////////////////////////////////////////////////
	// Byte collection and address formation
	wire [15:0] nextAddr = opcAddrReg + {14'h0000, len};
	// Second operand byte is the displacement for bit branches and reach is signed
	wire [7:0]  disp = bitBr ? byteData : b1Reg;
	wire [15:0] target = nextAddr + {{8{disp[7]}}, disp};

	always @(posedge clk) begin
		if (srst) begin
			stateReg     <= `OAG_ST_OPC;
			opcReg       <= 8'h00;
			b1Reg        <= 8'h00;
			opcAddrReg   <= 16'h0000;
			decDone      <= 1'b0;
			decMode      <= 3'h0;
			decGroup     <= 3'h0;
			decLength    <= 2'h0;
			decBitBranch <= 1'b0;
			decHasAddr   <= 1'b0;
			operandAddr  <= 16'h0000;
			immData      <= 8'h00;
			nextPc       <= 16'h0000;
			branchTaken  <= 1'b0;
			branchTarget <= 16'h0000;
		end else if (clkEn) begin
			decDone <= 1'b0;
			case (stateReg)
				`OAG_ST_OPC: if (byteValid) begin
					opcReg     <= byteData;
					opcAddrReg <= byteAddr;
					stateReg   <= `OAG_ST_B1;
				end
				`OAG_ST_B1: if (need == 2'd0) begin
					stateReg <= `OAG_ST_DONE;
				end else if (byteValid) begin
					b1Reg    <= byteData;
					stateReg <= (need == 2'd1) ? `OAG_ST_DONE : `OAG_ST_B2;
				end
				`OAG_ST_B2: if (byteValid) begin
					stateReg <= `OAG_ST_DONE;
					if (bitBr) begin
						branchTarget <= target;
						branchTaken  <= branchCond;
						nextPc       <= branchCond ? target : nextAddr;
					end else if (mode == `OAG_MODE_EXT)
						operandAddr <= {b1Reg, byteData};
					else
						operandAddr <= {b1Reg, byteData} + {8'h00, indexReg};
				end
				default: begin
					stateReg     <= `OAG_ST_OPC;
					decDone      <= 1'b1;
					decMode      <= mode;
					decGroup     <= group;
					decLength    <= len;
					decBitBranch <= bitBr;
					decHasAddr   <= ~(mode == `OAG_MODE_INH || mode == `OAG_MODE_IMM ||
						mode == `OAG_MODE_REL);
					if (mode == `OAG_MODE_IMM)
						immData <= b1Reg;
					if (!bitBr)
						nextPc <= nextAddr;
					branchTaken <= bitBr ? branchTaken : 1'b0;
					case (mode)
						`OAG_MODE_DIR: operandAddr <= {`OAG_ZERO8, b1Reg};
						`OAG_MODE_IX:  operandAddr <= {`OAG_ZERO8, indexReg};
						`OAG_MODE_IX1: operandAddr <= {8'h00, b1Reg} + {8'h00, indexReg};
						`OAG_MODE_INH, `OAG_MODE_IMM, `OAG_MODE_REL: operandAddr <= 16'h0000;
						default: operandAddr <= operandAddr;
					endcase
					if (relOnly) begin
						branchTarget <= target;
						branchTaken  <= branchCond;
						nextPc       <= branchCond ? target : nextAddr;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** dv/oag_monitor.sv ***
// Checker on the decode outputs of the operand address generator
`timescale 1ns/10ps
`default_nettype none
module oag_monitor (
	input wire logic        clk, srst, clkEn, byteValid, branchCond,
	input wire logic [7:0]  byteData, indexReg, immData,
	input wire logic [15:0] byteAddr, operandAddr, nextPc, branchTarget,
	input wire logic        decDone, decBitBranch, decHasAddr, branchTaken,
	input wire logic [2:0]  decMode, decGroup,
	input wire logic [1:0]  decLength
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_INH: assert property (decDone && decMode == 3'h0 |-> decLength == 2'h1 && !decHasAddr)
		else $error("bad inherent decode");
	AST_IMM: assert property (decDone && decMode == 3'h1 |-> decLength == 2'h2 && !decHasAddr)
		else $error("bad immediate decode");
	AST_DIR: assert property (decDone && decMode == 3'h2 |-> operandAddr[15:8] == 8'h00)
		else $error("direct high byte not zero");
	AST_BRB: assert property (decDone && decBitBranch |-> decLength == 2'h3 && decMode == 3'h2)
		else $error("bad bit branch decode");
	AST_EXT: assert property (decDone && decMode == 3'h3 |-> decLength == 2'h3)
		else $error("bad extended length");
	AST_IX: assert property (decDone && decMode == 3'h4 |-> decLength == 2'h1 && operandAddr < 16'h0100)
		else $error("bad indexed decode");
	AST_IX1: assert property (decDone && decMode == 3'h5 |-> decLength == 2'h2 && operandAddr <= 16'h01fe)
		else $error("bad offset indexed decode");
	AST_REL: assert property (decDone && branchTaken |-> nextPc == branchTarget)
		else $error("taken branch not at target");
	AST_GRP: assert property (decDone |-> decGroup <= 3'h4)
		else $error("group out of range");
	// Done is a single pulse; a stretched pulse would decode a byte twice
	AST_PULSE: assert property (decDone && clkEn |=> !decDone)
		else $error("done pulse stretched");
	COV_TAKEN: cover property (decDone && branchTaken);
	COV_BRB: cover property (decDone && decBitBranch);
	COV_IX2: cover property (decDone && decMode == 3'h6);
endmodule
bind oag_operand_address_generator oag_monitor mon (.*);
`default_nettype wire

// *** dv/oag_fetch_model.sv ***
// Instruction fetch model streaming bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module oag_fetch_model (
	input  wire logic        clk,
	output var  logic        byteValid,
	output var  logic [7:0]  byteData,
	output var  logic [15:0] byteAddr
);
	initial begin
		byteValid = 1'b0;
		byteData = 8'h00;
		byteAddr = 16'h0000;
	end
	// One byte per cycle; idle lines inverted so stale values never look valid
	task send(input [1:0] n, input [15:0] a, input [23:0] b);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			@(posedge clk);
			byteValid <= 1'b1;
			byteData <= b[23-8*i -: 8];
			byteAddr <= a + i[15:0];
		end
		@(posedge clk);
		byteValid <= 1'b0;
		byteData <= ~byteData;
		byteAddr <= ~byteAddr;
	endtask
endmodule
`default_nettype wire

// *** dv/test_operand_address_generator.sv ***
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module test_operand_address_generator;
	logic        clk, srst, clkEn, branchCond, byteValid, decDone;
	logic        decBitBranch, decHasAddr, branchTaken;
	logic [7:0]  indexReg, byteData, immData;
	logic [15:0] byteAddr, operandAddr, nextPc, branchTarget;
	logic [2:0]  decMode, decGroup;
	logic [1:0]  decLength;
	integer      failures = 0;
	integer      checks_done = 0;
	oag_fetch_model fm (.*);
	oag_operand_address_generator dut (.*);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input [15:0] s, input [15:0] e);
		checks_done = checks_done + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("[FAIL] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task dec(input [1:0] n, input [15:0] a, input [23:0] b, input [7:0] x, input c);
		integer t;
		@(posedge clk);
		indexReg <= x;
		branchCond <= c;
		fm.send(n, a, b);
		t = 0;
		while (decDone !== 1'b1 && t < 8) begin
			@(negedge clk);
			t = t + 1;
		end
		chk(t < 8, 1);
	endtask
	// Clock enable low must freeze the decoder and hold every result
	task t_hold;
		@(posedge clk);
		clkEn <= 1'b0;
		fm.send(1, 16'h0400, 24'h9d_0000);
		repeat (3) @(negedge clk);
		chk(decDone, 0);
		chk(nextPc, 16'h12b6);
		@(posedge clk);
		clkEn <= 1'b1;
		repeat (4) @(negedge clk);
		chk(decDone, 0);
		chk(nextPc, 16'h12b6);
	endtask
	task t_inh;
		dec(1, 16'h0100, 24'h9d_0000, 8'h00, 1'b0);
		chk({decLength, decHasAddr, decGroup}, 6'h14);
		chk(nextPc, 16'h0101);
		dec(1, 16'h0101, 24'h4c_0000, 8'h00, 1'b0);
		chk(decGroup, 1);
		dec(1, 16'h0102, 24'h42_0000, 8'h00, 1'b0);
		chk(decGroup, 0);
	endtask
	task t_mem;
		dec(2, 16'h0200, 24'ha6_5a00, 8'h00, 1'b0);
		chk({immData, decMode, decLength, decGroup}, 16'h5a30);
		dec(2, 16'h0202, 24'hb6_8000, 8'h00, 1'b0);
		chk(operandAddr, 16'h0080);
		dec(3, 16'h0204, 24'hc6_1234, 8'h00, 1'b0);
		chk(operandAddr, 16'h1234);
	endtask
	task t_idx;
		dec(1, 16'h0300, 24'hf6_0000, 8'hff, 1'b0);
		chk(operandAddr, 16'h00ff);
		dec(2, 16'h0301, 24'he6_ff00, 8'hff, 1'b0);
		chk(operandAddr, 16'h01fe);
		dec(3, 16'h0303, 24'hd6_ffff, 8'h02, 1'b0);
		chk(operandAddr, 16'h0001);
	endtask
	task t_br;
		dec(2, 16'h0000, 24'h20_8000, 8'h00, 1'b1);
		chk(nextPc, 16'hff82);
		dec(2, 16'h1000, 24'h20_7f00, 8'h00, 1'b0);
		chk(branchTaken, 0);
		chk(nextPc, 16'h1002);
		chk(branchTarget, 16'h1081);
		dec(3, 16'h1234, 24'h00_457f, 8'h00, 1'b1);
		chk(decBitBranch, 1);
		chk(operandAddr, 16'h0045);
		chk(branchTaken, 1);
		chk(nextPc, 16'h12b6);
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		clkEn = 1'b1;
		indexReg = 8'h00;
		branchCond = 1'b0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_inh;
		t_mem;
		t_idx;
		t_br;
		t_hold;
		report_and_stop;
	end
	initial begin
		#20000;
		failures = failures + 1;
		report_and_stop;
	end
endmodule
`default_nettype wire
